// [spi_reg_host.sv]
`timescale 1ns/10ps
`include "spi_link_defs.svh"
module spi_reg_host (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  spi_link_if.host        link,
  input  wire logic       req,
  input  wire logic       req_write,
  input  wire logic [6:0] req_addr,
  input  wire logic [7:0] req_data,
  input  wire logic       req_more,
  input  wire logic [7:0] more_data,
  output logic            busy,
  output logic            need_data,
  output logic            rd_valid,
  output logic [7:0]      rd_data
);
  localparam logic [3:0] HALF = 4'(`SCLK_HALF_CYCLES);
  spi_link_pkg::host_st_t s_q;
  spi_link_pkg::host_st_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.sdi_sync  = {s_q.sdi_sync[0], link.sdo};
    s_d.rd_valid  = 1'b0;
    s_d.need_data = 1'b0;
    unique case (s_q.state)
      spi_link_pkg::H_IDLE: begin
        s_d.sel_n = 1'b1;
        s_d.sclk  = 1'b0;
        s_d.busy  = 1'b0;
        if (req) begin
          s_d.state      = spi_link_pkg::H_SHIFT;
          s_d.busy       = 1'b1;
          s_d.sel_n      = 1'b0;
          s_d.tx_shift   = {req_write, req_addr, req_data};
          s_d.sdo        = req_write;
          s_d.bit_cnt    = 4'd0;
          s_d.div_cnt    = 4'd0;
          s_d.first_byte = 1'b1;
          s_d.rd_mode    = (req_write == `RW_READ);
        end
      end
      spi_link_pkg::H_SHIFT: begin
        // divider paces the serial clock at or below the maximum rate
        if (s_q.div_cnt == HALF - 4'd1) begin
          s_d.div_cnt = 4'd0;
          s_d.sclk    = ~s_q.sclk;
          if (s_q.sclk) begin
            // falling edge: advance output data
            s_d.tx_shift = {s_q.tx_shift[14:0], 1'b0};
            s_d.sdo      = s_q.tx_shift[14];
            s_d.bit_cnt  = s_q.bit_cnt + 4'd1;
            if (s_q.bit_cnt == 4'd15) begin
              // only read frames hand data back, burst bytes included
              s_d.rd_valid = s_q.rd_mode;
              s_d.rd_data  = s_q.rx_shift;
              if (req_more) begin
                s_d.bit_cnt    = 4'd8;
                s_d.first_byte = 1'b0;
                s_d.tx_shift   = {more_data, 8'h00};
                s_d.sdo        = more_data[7];
                s_d.need_data  = 1'b1;
              end else begin
                s_d.state   = spi_link_pkg::H_GAP;
                s_d.sclk    = 1'b0;
                // deselect with the last falling edge, so the device never shifts past the
                // last data bit and its output holds that bit until select rises
                s_d.sel_n   = 1'b1;
                s_d.bit_cnt = 4'd0;
              end
            end
          end else begin
            s_d.rx_shift = {s_q.rx_shift[6:0], s_q.sdi_sync[1]};
          end
        end else begin
          s_d.div_cnt = s_q.div_cnt + 4'd1;
        end
      end
      spi_link_pkg::H_GAP: begin
        s_d.sel_n   = 1'b1;
        s_d.sdo     = 1'b0;
        s_d.div_cnt = s_q.div_cnt + 4'd1;
        if (s_q.div_cnt == 4'(`SEL_GAP_CYCLES)) begin
          s_d.state   = spi_link_pkg::H_IDLE;
          s_d.div_cnt = 4'd0;
        end
      end
      default: s_d.state = spi_link_pkg::H_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q       <= '0;
      s_q.sel_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.sclk     = s_q.sclk;
  assign link.sdi      = s_q.sdo;
  assign link.select_n = s_q.sel_n;
  assign busy          = s_q.busy;
  assign need_data     = s_q.need_data;
  assign rd_valid      = s_q.rd_valid;
  assign rd_data       = s_q.rd_data;
endmodule

// [spi_link_defs.svh]
`ifndef SPI_LINK_DEFS_SVH
`define SPI_LINK_DEFS_SVH
`define FRAME_BITS        16
`define BYTE_BITS         8
`define ADDR_BITS         7
`define REG_COUNT         128
`define RW_WRITE          1'b1
`define RW_READ           1'b0
`define CORE_CLK_MHZ      125
`define SCLK_MAX_MHZ      10
// half period of the generated serial clock, rounded up so the rate stays at or below the maximum
`define SCLK_HALF_CYCLES  ((`CORE_CLK_MHZ + 2 * `SCLK_MAX_MHZ - 1) / (2 * `SCLK_MAX_MHZ))
`define SEL_GAP_CYCLES    8
`define REG_RESET_VALUE   8'h00
`endif

// [spi_link_pkg.sv]
package spi_link_pkg;
  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_SHIFT = 2'b01,
    H_GAP   = 2'b11
  } host_state_t;

  typedef struct packed {
    logic [1:0] sclk_sync;
    logic [1:0] sel_sync;
    logic [1:0] sdi_sync;
    logic       sclk_prev;
    logic       in_frame;
    logic [2:0] bit_cnt;
    logic       hdr_done;
    logic       is_write;
    logic [6:0] addr;
    logic [7:0] shift_in;
    logic [7:0] shift_out;
    logic       sdo;
    logic       wr_pulse;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;
  } dev_state_t;

  typedef struct packed {
    host_state_t state;
    logic [3:0]  div_cnt;
    logic        sclk;
    logic        sel_n;
    logic        sdo;
    logic [1:0]  sdi_sync;
    logic [15:0] tx_shift;
    logic [7:0]  rx_shift;
    logic [3:0]  bit_cnt;
    logic        first_byte;
    logic [7:0]  rd_data;
    logic        rd_valid;
    logic        busy;
    logic        need_data;
    logic        rd_mode;
  } host_st_t;
endpackage

// [spi_link_if.sv]
`timescale 1ns/10ps
interface spi_link_if;
  logic sclk;
  logic sdi;
  logic select_n;
  logic sdo_o;
  logic sdo_oe;
  // internal pull-up when the device does not drive
  logic sdo;
  assign sdo = sdo_oe ? sdo_o : 1'b1;

  modport device (
    input  sclk,
    input  sdi,
    input  select_n,
    output sdo_o,
    output sdo_oe
  );
  modport host (
    output sclk,
    output sdi,
    output select_n,
    input  sdo
  );
endinterface

// [spi_reg_device.sv]
`timescale 1ns/10ps
`include "spi_link_defs.svh"
module spi_reg_device (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  spi_link_if.device      link,
  output logic            wr_strobe,
  output logic [6:0]      wr_addr,
  output logic [7:0]      wr_data
);
  spi_link_pkg::dev_state_t s_q;
  spi_link_pkg::dev_state_t s_d;
  logic [7:0] regs_q [`REG_COUNT];
  logic       sdo_oe_q;

  logic sclk_s;
  logic sel_n_s;
  logic sdi_s;
  logic rise;
  logic fall;
  logic [7:0] byte_in;
  assign sclk_s  = s_q.sclk_sync[1];
  assign sel_n_s = s_q.sel_sync[1];
  assign sdi_s   = s_q.sdi_sync[1];
  assign rise    = ~sel_n_s & s_q.in_frame & sclk_s & ~s_q.sclk_prev;
  assign fall    = ~sel_n_s & s_q.in_frame & ~sclk_s & s_q.sclk_prev;
  assign byte_in = {s_q.shift_in[6:0], sdi_s};

  always_comb begin
    s_d = s_q;
    s_d.sclk_sync = {s_q.sclk_sync[0], link.sclk};
    s_d.sel_sync  = {s_q.sel_sync[0], link.select_n};
    s_d.sdi_sync  = {s_q.sdi_sync[0], link.sdi};
    s_d.sclk_prev = sclk_s;
    s_d.wr_pulse  = 1'b0;
    if (sel_n_s) begin
      s_d.in_frame = 1'b0;
      s_d.bit_cnt  = 3'd0;
      s_d.hdr_done = 1'b0;
      s_d.sdo      = 1'b1;
    end else if (!s_q.in_frame) begin
      // first cycle with select low only marks the frame as started; serial edges are counted from the next cycle
      s_d.in_frame = 1'b1;
    end else if (rise) begin
      s_d.shift_in = byte_in;
      s_d.bit_cnt  = s_q.bit_cnt + 3'd1;
      if (s_q.bit_cnt == 3'd7) begin
        if (!s_q.hdr_done) begin
          s_d.hdr_done  = 1'b1;
          s_d.is_write  = (byte_in[7] == `RW_WRITE);
          s_d.addr      = byte_in[6:0];
          s_d.shift_out = regs_q[byte_in[6:0]];
        end else begin
          if (s_q.is_write) begin
            s_d.wr_pulse = 1'b1;
            s_d.wr_addr  = s_q.addr;
            s_d.wr_data  = byte_in;
          end
          s_d.addr      = s_q.addr + 7'd1;
          s_d.shift_out = regs_q[s_q.addr + 7'd1];
        end
      end
    end else if (fall && s_q.hdr_done && !s_q.is_write) begin
      s_d.sdo       = s_q.shift_out[7];
      s_d.shift_out = {s_q.shift_out[6:0], 1'b0};
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.sclk_sync <= 2'b00;
      s_q.sel_sync  <= 2'b11;
      s_q.sdo       <= 1'b1;
      sdo_oe_q      <= 1'b0;
    end else begin
      s_q      <= s_d;
      sdo_oe_q <= ~sel_n_s & s_q.hdr_done & ~s_q.is_write;
    end
  end

  // register array has no reset: contents are undefined until written, as with real storage
  always_ff @(posedge core_clk) begin
    if (s_q.wr_pulse) begin
      regs_q[s_q.wr_addr] <= s_q.wr_data;
    end
  end

  assign link.sdo_o  = s_q.sdo;
  assign link.sdo_oe = sdo_oe_q;
  assign wr_strobe   = s_q.wr_pulse;
  assign wr_addr     = s_q.wr_addr;
  assign wr_data     = s_q.wr_data;
endmodule

// [spi_link_assertions.sv]
`timescale 1ns/10ps
module spi_link_assertions (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic select_n,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  input wire logic sdo
);
  // rising serial edges seen in the current frame
  logic [7:0] rise_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      rise_q <= 8'h00;
    else if (select_n)
      rise_q <= 8'h00;
    else if ($rose(sclk))
      rise_q <= rise_q + 8'h01;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // release lags select by the input synchroniser
  property p_idle; select_n[*5] |-> sdo; endproperty
  a_idle: assert property (p_idle) else $error("sdo low while idle");
  property p_oe; select_n[*5] |-> !sdo_oe; endproperty
  a_oe: assert property (p_oe) else $error("sdo driven while idle");
  property p_hi; $rose(sclk) |-> sclk[*7]; endproperty
  a_hi: assert property (p_hi) else $error("sclk high too short");
  property p_lo; $fell(sclk) |-> !sclk[*7]; endproperty
  a_lo: assert property (p_lo) else $error("sclk low too short");
  property p_start; $fell(select_n) |-> !sclk; endproperty
  a_start: assert property (p_start) else $error("select fell with sclk high");
  property p_sdi; $changed(sdi) && !select_n |-> !sclk; endproperty
  a_sdi: assert property (p_sdi) else $error("sdi moved with sclk high");
  property p_sdo; $changed(sdo) && !select_n |-> !sclk; endproperty
  a_sdo: assert property (p_sdo) else $error("sdo moved with sclk high");
  property p_frame; $rose(select_n) |-> rise_q[2:0] == 3'h0 && rise_q >= 8'h10; endproperty
  a_frame: assert property (p_frame) else $error("frame not whole bytes");
  property p_gap; $rose(select_n) |-> select_n[*8]; endproperty
  a_gap: assert property (p_gap) else $error("select gap short");
  c_burst: cover property ($rose(select_n) && rise_q == 8'h18);
  c_drive: cover property ($rose(sdo_oe));
  c_zero: cover property (!select_n && !sdo);
endmodule

// [testbench.sv]
`timescale 1ns/10ps
module testbench;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        req = 1'b0;
  logic        req_write = 1'b0;
  logic        req_more = 1'b0;
  logic [6:0]  req_addr = 7'h00;
  logic [7:0]  req_data = 8'h00;
  logic [7:0]  more_data = 8'h00;
  logic        busy, need_data, rd_valid, wr_strobe;
  logic [7:0]  rd_data, wr_data;
  logic [6:0]  wr_addr;
  logic [23:0] din, dout;
  logic [14:0] wq[$];
  logic [7:0]  rq[$];
  int          n_errors = 0;
  int          checked = 0;
  int          nbits = 0;
  always #4 core_clk = ~core_clk;
  spi_link_if lnk ();
  spi_reg_device i_spi_reg_device (.core_clk(core_clk), .rst_n(rst_n), .link(lnk.device),
    .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data));
  spi_reg_host i_spi_reg_host (.core_clk(core_clk), .rst_n(rst_n), .link(lnk.host),
    .req(req), .req_write(req_write), .req_addr(req_addr), .req_data(req_data),
    .req_more(req_more), .more_data(more_data), .busy(busy), .need_data(need_data),
    .rd_valid(rd_valid), .rd_data(rd_data));
  spi_link_assertions u_chk (.core_clk(core_clk), .rst_n(rst_n), .sclk(lnk.sclk),
    .sdi(lnk.sdi), .select_n(lnk.select_n), .sdo_o(lnk.sdo_o), .sdo_oe(lnk.sdo_oe),
    .sdo(lnk.sdo));
  always @(posedge core_clk) begin
    if (wr_strobe === 1'b1)
      wq.push_back({wr_addr, wr_data});
    if (rd_valid === 1'b1)
      rq.push_back(rd_data);
  end
  // the wire as a bystander sees it, sampled on the rising serial edge
  always @(posedge lnk.sclk) begin
    if (lnk.select_n === 1'b0) begin
      din = {din[22:0], lnk.sdi};
      dout = {dout[22:0], lnk.sdo};
      nbits++;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    if (n_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic frame(input logic w, input logic [6:0] a, input logic [7:0] d0, d1,
                       input logic more);
    int k;
    wq.delete();
    rq.delete();
    nbits = 0;
    req_write = w;
    req_addr = a;
    req_data = d0;
    more_data = d1;
    req_more = more;
    req = 1'b1;
    k = 0;
    do begin
      @(negedge core_clk);
      req = 1'b0;
      // one extra byte only: stop offering once it was taken
      if (need_data === 1'b1)
        req_more = 1'b0;
      k++;
    end while ((busy !== 1'b0 || k < 2) && k < 1000);
  endtask
  task automatic t_write;
    frame(1'b1, 7'h05, 8'hA5, 8'h00, 1'b0);
    chk(16'(wq.size()), 16'h0001);
    chk({1'b0, wq[0]}, {1'b0, 7'h05, 8'hA5});
    chk(din[15:0], {1'b1, 7'h05, 8'hA5});
    chk(16'(nbits), 16'h0010);
    frame(1'b1, 7'h06, 8'h3C, 8'h00, 1'b0);
    chk({1'b0, wq[0]}, {1'b0, 7'h06, 8'h3C});
  endtask
  task automatic t_read;
    // data byte of ones must not land anywhere
    frame(1'b0, 7'h05, 8'hFF, 8'h00, 1'b0);
    chk(16'(wq.size()), 16'h0000);
    chk({8'h00, din[15:8]}, {8'h00, 1'b0, 7'h05});
    chk({8'h00, dout[7:0]}, 16'h00A5);
    chk({8'h00, rq[rq.size() - 1]}, 16'h00A5);
    frame(1'b0, 7'h06, 8'hFF, 8'h00, 1'b0);
    chk({8'h00, rq[rq.size() - 1]}, 16'h003C);
  endtask
  task automatic t_burst_write;
    frame(1'b1, 7'h7F, 8'h81, 8'h18, 1'b1);
    chk(16'(wq.size()), 16'h0002);
    chk({1'b0, wq[1]}, {1'b0, 7'h00, 8'h18});
    chk(16'(nbits), 16'h0018);
  endtask
  task automatic t_burst_read;
    frame(1'b0, 7'h7F, 8'hFF, 8'hFF, 1'b1);
    chk(dout[15:0], 16'h8118);
    chk({rq[rq.size() - 2], rq[rq.size() - 1]}, 16'h8118);
    chk(16'(wq.size()), 16'h0000);
  endtask
  initial begin
    repeat (10) @(negedge core_clk);
    rst_n = 1'b1;
    t_write();
    t_read();
    t_burst_write();
    t_burst_read();
    end_sim();
  end
  initial begin
    #60000;
    n_errors++;
    end_sim();
  end
endmodule
